// [core/wdr_params.svh]
// Purpose: constants for the watchdog and reset-source block
// Assumes: aclk at 50 MHz, AXI4-Lite register window
// Notes: definitions only
`ifndef WDR_PARAMS_SVH
`define WDR_PARAMS_SVH
`define WDR_CLK_PERIOD_PS 20000
`define WDR_OFF_CONTROL 8'h00
`define WDR_OFF_RELOAD 8'h04
`define WDR_OFF_COMMAND 8'h08
`define WDR_OFF_IRQ_STATUS 8'h0C
`define WDR_OFF_IRQ_MASK 8'h10
`define WDR_OFF_COUNT 8'h14
`define WDR_CTL_PRESCALE 0
`define WDR_CTL_DISABLE 1
`define WDR_CTL_BIDIR 2
`define WDR_CTL_INIT_DONE 3
`define WDR_CTL_WD_FLAG 4
`define WDR_CTL_SW_FLAG 5
`define WDR_CTL_SHORT_FLAG 6
`define WDR_CTL_LONG_FLAG 7
`define WDR_CTL_PON_FLAG 8
`define WDR_CMD_SERVICE 0
`define WDR_CMD_END_INIT 1
`define WDR_CMD_SW_RESET 2
`define WDR_IRQ_OVERFLOW 0
`define WDR_IRQ_RESET_SEEN 1
`define WDR_FILTER_NS 500
`define WDR_FILTER_CYC ((`WDR_FILTER_NS * 1000 + `WDR_CLK_PERIOD_PS - 1) / `WDR_CLK_PERIOD_PS)
`define WDR_LONG_HALF_PERIODS 1044
`define WDR_LONG_CYC ((`WDR_LONG_HALF_PERIODS + 1) / 2 + `WDR_FILTER_CYC)
`define WDR_RESET_OUT_CYC 16'd1024
`define WDR_DIV_SLOW 128
`define WDR_DIV_FAST 2
`endif

// [core/wdr_pkg.sv]
// Purpose: types for the watchdog and reset-source block
// Assumes: nothing
// Notes: offsets live in wdr_params.svh
package wdr_pkg;
  typedef enum logic [1:0] {WDR_IDLE, WDR_W_RESP, WDR_R_RESP} wdr_bus_t;
endpackage

// [core/wdr_watchdog.sv]
// Purpose: 16-bit watchdog with reset-cause recording behind AXI4-Lite
// Assumes: reset pins are asynchronous and synchronised here
// Notes: chip reset is modelled as reset_request_out plus aresetn
//
// What this block does
// - the watchdog runs and is enabled after every kind of reset with no software help.
// - a disable is honoured only while end-of-initialisation has not yet run.
// - an overflow raises internal reset and pulls the reset output pin low.
// - the control register shows the last reset cause flags.
// - the end-of-initialisation command clears every cause flag.
// - the counter is 16 bits and steps on clock divided by 2 or by 128.
// - each service loads the upper byte from the reload value.
// - overflow time is (256 - reload) * 256 * divider clock periods.
// - five reset sources each set their own cause flag.
// - with mode pin high, a reset input low past the long threshold flags a long reset.
// - with mode pin high, a pulse past the filter but not the long threshold flags a short reset.
// - on watchdog or software reset the mode pin only matters when bidirectional reset is on.
//
// Decided for this implementation: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "wdr_params.svh"
module wdr_watchdog import wdr_pkg::*; #(
  parameter int RESET_OUT_CYC = 1024
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pins from external reset circuitry
  input wire logic reset_input_pin_n,
  input wire logic reset_mode_pin,
  input wire logic power_on_event,
  // pins to the outside
  output logic reset_output_pin_n,
  output logic reset_input_drive_oe,
  output logic reset_request_out,
  output logic irq,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int FILTER_CYC = `WDR_FILTER_CYC;
  localparam int LONG_CYC = `WDR_LONG_CYC;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [1:0] rst_in_sync;
  logic [1:0] mode_sync;
  logic [1:0] pon_sync;
  // first stage feeds only the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rst_in_sync <= 2'h3;
      mode_sync <= 2'h0;
      pon_sync <= 2'h0;
    end else begin
      rst_in_sync <= {rst_in_sync[0], reset_input_pin_n};
      mode_sync <= {mode_sync[0], reset_mode_pin};
      pon_sync <= {pon_sync[0], power_on_event};
    end
  end
  wire rst_low = !rst_in_sync[1];
  wire mode_high = mode_sync[1];

  // ----------------------------------------
  // bus state and register storage
  // ----------------------------------------
  wdr_bus_t bus_state;
  logic [7:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic w_held;
  logic prescale_sel;
  logic disabled;
  logic bidir_en;
  logic init_done;
  logic [4:0] cause;
  logic [7:0] reload;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic [15:0] count;
  logic [6:0] prescale_cnt;
  logic [15:0] out_cnt;
  logic [11:0] low_cnt;
  logic do_write;
  logic w_strb0;
  logic cause_init = 1'b0;

  assign s_axi_awready = (bus_state == WDR_IDLE) && !aw_held;
  assign s_axi_wready = (bus_state == WDR_IDLE) && !w_held;
  assign s_axi_arready = (bus_state == WDR_IDLE) && !aw_held && !w_held && !s_axi_awvalid && !s_axi_wvalid;
  assign do_write = (bus_state == WDR_IDLE) && aw_held && w_held;
  wire wr_ctl = do_write && aw_addr == `WDR_OFF_CONTROL;
  wire wr_cmd = do_write && aw_addr == `WDR_OFF_COMMAND;
  wire cmd_service = wr_cmd && w_data[`WDR_CMD_SERVICE];
  wire cmd_end_init = wr_cmd && w_data[`WDR_CMD_END_INIT];
  wire cmd_sw_reset = wr_cmd && w_data[`WDR_CMD_SW_RESET];
  wire mapped_w = aw_addr == `WDR_OFF_CONTROL || aw_addr == `WDR_OFF_RELOAD || aw_addr == `WDR_OFF_COMMAND
    || aw_addr == `WDR_OFF_IRQ_STATUS || aw_addr == `WDR_OFF_IRQ_MASK || aw_addr == `WDR_OFF_COUNT;

  // axi4-lite handshake: address and data captured in any order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_state <= WDR_IDLE;
      aw_addr <= 8'h00;
      aw_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_held <= 1'b0;
      w_strb0 <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= {s_axi_awaddr[7:2], 2'h0};
        aw_held <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_held <= 1'b1;
        w_strb0 <= s_axi_wstrb[0];
      end
      unique case (bus_state)
        WDR_IDLE: begin
          if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped_w ? 2'h0 : 2'h2;
            bus_state <= WDR_W_RESP;
          end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            unique case ({s_axi_araddr[7:2], 2'h0})
              `WDR_OFF_CONTROL: s_axi_rdata <= {23'h0, cause, init_done, bidir_en, disabled, prescale_sel};
              `WDR_OFF_RELOAD: s_axi_rdata <= {24'h0, reload};
              `WDR_OFF_COMMAND: s_axi_rdata <= 32'h0000_0000;
              `WDR_OFF_IRQ_STATUS: s_axi_rdata <= {30'h0, irq_status};
              `WDR_OFF_IRQ_MASK: s_axi_rdata <= {30'h0, irq_mask};
              `WDR_OFF_COUNT: s_axi_rdata <= {16'h0, count};
              default: begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= 2'h2;
              end
            endcase
            bus_state <= WDR_R_RESP;
          end
        end
        WDR_W_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            bus_state <= WDR_IDLE;
          end
        end
        WDR_R_RESP: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            bus_state <= WDR_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // control and reload registers
  // ----------------------------------------
  // chip reset is aresetn, so every reset restarts the dog enabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prescale_sel <= 1'b0;
      disabled <= 1'b0;
      bidir_en <= 1'b0;
      init_done <= 1'b0;
      reload <= 8'h00;
    end else begin
      if (wr_ctl) begin
        prescale_sel <= w_data[`WDR_CTL_PRESCALE];
        bidir_en <= w_data[`WDR_CTL_BIDIR];
        if (!init_done) begin
          disabled <= w_data[`WDR_CTL_DISABLE];
        end
      end
      if (do_write && aw_addr == `WDR_OFF_RELOAD && w_strb0) begin
        reload <= w_data[7:0];
      end
      if (cmd_end_init) begin
        init_done <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // prescaler and 16-bit counter
  // ----------------------------------------
  wire [6:0] div_last = prescale_sel ? 7'(`WDR_DIV_SLOW - 1) : 7'(`WDR_DIV_FAST - 1);
  wire tick = (prescale_cnt >= div_last);
  wire overflow = tick && count == 16'hFFFF && !disabled && out_cnt == 16'h0000;
  // time to overflow is (256 - reload) * 256 * divider
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prescale_cnt <= 7'h00;
      count <= 16'h0000;
    end else if (cmd_service) begin
      prescale_cnt <= 7'h00;
      count <= {reload, 8'h00};
    end else if (!disabled) begin
      prescale_cnt <= tick ? 7'h00 : prescale_cnt + 7'h01;
      if (tick) begin
        count <= count + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // reset output and internal reset request
  // ----------------------------------------
  wire chip_reset_event = overflow || cmd_sw_reset;
  // not cleared by aresetn: the chip reset it requests must not cut its own pulse
  always_ff @(posedge aclk) begin
    if (!cause_init) begin
      out_cnt <= 16'h0000;
      reset_output_pin_n <= 1'b1;
      reset_request_out <= 1'b0;
      reset_input_drive_oe <= 1'b0;
    end else if (chip_reset_event) begin
      out_cnt <= 16'(RESET_OUT_CYC);
      reset_output_pin_n <= 1'b0;
      reset_request_out <= 1'b1;
      reset_input_drive_oe <= bidir_en && mode_high;
    end else if (out_cnt != 16'h0000) begin
      out_cnt <= out_cnt - 16'h0001;
      if (out_cnt == 16'h0001) begin
        reset_output_pin_n <= 1'b1;
        reset_request_out <= 1'b0;
        reset_input_drive_oe <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // reset-input pulse measurement and cause flags
  // ----------------------------------------
  // pulses shorter than the filter time are ignored, as external logic must exceed it
  wire rst_rise = !rst_low && low_cnt != 12'h000;
  wire hw_short = rst_rise && mode_high && int'(low_cnt) > FILTER_CYC && int'(low_cnt) <= LONG_CYC;
  // long is flagged whatever the mode pin, as an asynchronous reset flags it too
  wire hw_long = rst_rise && int'(low_cnt) > LONG_CYC;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_cnt <= 12'h000;
    end else if (rst_low) begin
      if (low_cnt != 12'hFFF) begin
        low_cnt <= low_cnt + 12'h001;
      end
    end else begin
      low_cnt <= 12'h000;
    end
  end
  // cause flags survive aresetn; only end-of-init clears them, events win
  wire [4:0] cause_set = {pon_sync[1], hw_long, hw_short, cmd_sw_reset, overflow};
  always_ff @(posedge aclk) begin
    if (!cause_init) begin
      cause <= 5'h00;
      cause_init <= 1'b1;
    end else begin
      cause <= (cmd_end_init ? 5'h00 : cause) | cause_set;
    end
  end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= 2'h0;
      irq_mask <= 2'h0;
    end else begin
      if (do_write && aw_addr == `WDR_OFF_IRQ_MASK) begin
        irq_mask <= w_data[1:0];
      end
      irq_status <= (irq_status & ~((do_write && aw_addr == `WDR_OFF_IRQ_STATUS) ? w_data[1:0] : 2'h0))
        | {hw_short || hw_long, overflow};
    end
  end
  assign irq = |(irq_status & irq_mask);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_overflow_pin: assert property (@(posedge aclk) disable iff (!aresetn)
    overflow |=> !reset_output_pin_n && reset_request_out) else $error("overflow did not pull reset out");
  a_service_load: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_service |=> count == {$past(reload), 8'h00}) else $error("service load wrong");
  a_low_byte_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_service |=> count[7:0] == 8'h00) else $error("low byte not cleared");
  a_disable_locked: assert property (@(posedge aclk) disable iff (!aresetn)
    init_done && !disabled |=> !disabled) else $error("disable after end of init");
  a_enabled_reset: assert property (@(posedge aclk)
    !aresetn |=> !disabled) else $error("dog not enabled after reset");
  a_endinit_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_end_init && !overflow && !cmd_sw_reset && !hw_short && !hw_long && !pon_sync[1] |=> cause == 5'h00)
    else $error("cause flags not cleared");
  a_wd_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    overflow |=> cause[0]) else $error("watchdog flag missing");
  a_prescale_step: assert property (@(posedge aclk) disable iff (!aresetn)
    !disabled && !cmd_service && !tick |=> count == $past(count)) else $error("count moved without tick");
  a_bidir_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    chip_reset_event && !(bidir_en && mode_high) |=> !reset_input_drive_oe) else $error("drive without bidir");
  c_overflow: cover property (@(posedge aclk) disable iff (!aresetn) overflow);
  c_short: cover property (@(posedge aclk) disable iff (!aresetn) hw_short);
  c_long: cover property (@(posedge aclk) disable iff (!aresetn) hw_long);
  c_service: cover property (@(posedge aclk) disable iff (!aresetn) cmd_service);
endmodule

// [test/wdr_ext_circuit.sv]
// Purpose: model of the reset circuitry outside the watchdog block
// Assumes: reset input wire has a pull-up, pulses counted in aclk cycles
// Notes: pulse lengths are the caller's choice
`timescale 1ns/1ps
// ----------------------------------------
// external reset circuitry
// ----------------------------------------
module wdr_ext_circuit (
  // clock
  input wire logic aclk,
  // device side
  input wire logic drive_oe,
  output logic pin_n,
  output logic mode,
  output logic pon
);
  logic hold_low;
  // idle levels: released pin, synchronous mode
  initial begin
    hold_low = 1'b0;
    mode = 1'b1;
    pon = 1'b0;
  end
  // open-drain wire, either party pulling low wins
  assign pin_n = ~(hold_low | drive_oe);
  // hold low for len cycles, below, just past or well past the input filter
  task automatic pulse(input int len);
    @(posedge aclk);
    hold_low <= 1'b1;
    repeat (len) @(posedge aclk);
    hold_low <= 1'b0;
  endtask
  task automatic set_mode(input logic v);
    @(posedge aclk);
    mode <= v;
  endtask
  // short pulse, long enough to pass the synchroniser
  task automatic pon_pulse();
    @(posedge aclk);
    pon <= 1'b1;
    repeat (4) @(posedge aclk);
    pon <= 1'b0;
  endtask
endmodule

// [test/wdr_watchdog_tb.sv]
// Purpose: self-checking bench for the watchdog and reset-source block
// Assumes: chip reset is fed back from reset_request_out into aresetn
// Notes: reset output time shortened to 8 cycles
`timescale 1ns/1ps
`include "wdr_params.svh"
// ----------------------------------------
// bench top
// ----------------------------------------
module wdr_watchdog_tb;
  localparam int OUT_CYC = 8;
  typedef struct packed {logic [31:0] d; logic [31:0] m; logic [1:0] r;} wdr_note_t;
  logic aclk, boot, oe_seen;
  logic aresetn = 1'b0;
  logic [7:0] awaddr, araddr, rl;
  logic [31:0] wdata, rdata, rd_val, c0, c1;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic pin_n, mode, pon, rst_out_n, oe, req, irq;
  int t, lo, n_mismatch, num_checks;
  wdr_note_t notes[$];
  logic [1:0] bnotes[$];
  wdr_watchdog #(.RESET_OUT_CYC(OUT_CYC)) wdr_watchdog_i (
    .aclk(aclk), .aresetn(aresetn), .reset_input_pin_n(pin_n), .reset_mode_pin(mode),
    .power_on_event(pon), .reset_output_pin_n(rst_out_n), .reset_input_drive_oe(oe),
    .reset_request_out(req), .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  wdr_ext_circuit wdr_ext_circuit_i (.aclk(aclk), .drive_oe(oe), .pin_n(pin_n), .mode(mode), .pon(pon));
  // 50 MHz clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // chip reset: boot reset or the block's own request
  always @(posedge aclk) aresetn <= ~(boot | req);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // response monitor, sampled before the handshake edge
  always @(negedge aclk) begin
    if (bvalid === 1'b1 && bready === 1'b1 && bnotes.size() > 0) begin
      check({30'h0, bresp}, {30'h0, bnotes[0]});
      void'(bnotes.pop_front());
    end
    if (rvalid === 1'b1 && rready === 1'b1 && notes.size() > 0) begin
      check(rdata & notes[0].m, notes[0].d);
      check({30'h0, rresp}, {30'h0, notes[0].r});
      void'(notes.pop_front());
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw = 1'b0;
    logic w = 1'b0;
    logic b = 1'b0;
    bnotes.push_back(er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b) begin
      @(negedge aclk);
      aw = awvalid & awready;
      w = wvalid & wready;
      b = bvalid & bready;
      @(posedge aclk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input logic [1:0] er);
    logic ar = 1'b0;
    logic r = 1'b0;
    notes.push_back('{d: e & m, m: m, r: er});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r) begin
      @(negedge aclk);
      ar = arvalid & arready;
      r = rvalid & rready;
      if (r) rd_val = rdata;
      @(posedge aclk);
      if (ar) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask
  // two counter reads gap cycles apart, upper half must stay zero
  task automatic span(input int gap);
    rd(`WDR_OFF_COUNT, 32'h0, 32'hFFFF0000, 2'b00);
    c0 = rd_val;
    repeat (gap) @(posedge aclk);
    rd(`WDR_OFF_COUNT, 32'h0, 32'hFFFF0000, 2'b00);
    c1 = rd_val;
  endtask
  // time to reset output low, then its low time and drive enable
  task automatic watch_out();
    t = 0;
    lo = 0;
    oe_seen = 1'b0;
    while (rst_out_n !== 1'b0) begin
      @(negedge aclk);
      t++;
    end
    check({31'h0, req}, 32'h1);
    while (rst_out_n === 1'b0) begin
      oe_seen = oe_seen | oe;
      @(negedge aclk);
      lo++;
    end
    check(32'(lo), 32'(OUT_CYC));
  endtask
  // slack covers synchroniser and filter latency
  task automatic wait_idle();
    repeat (8) @(posedge aclk);
    while (!(aresetn === 1'b1 && rst_out_n === 1'b1)) @(posedge aclk);
    @(posedge aclk);
  endtask
  task automatic test_done();
    // answers that never came count against the run
    n_mismatch += notes.size() + bnotes.size();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // main sequence
  initial begin
    int lens[3] = '{10, 30, 600};
    logic [31:0] fexp[3] = '{32'h0, 32'h40, 32'h80};
    logic [31:0] fmsk[3] = '{32'hC0, 32'hC0, 32'h80};
    boot = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = {16'h0, 32'h0, 4'hF};
    void'($urandom(32'h293AB41D));
    repeat (2) @(posedge aclk);
    boot <= 1'b0;
    wait_idle();
    rd(`WDR_OFF_CONTROL, 32'h0, 32'hE, 2'b00);
    span(300);
    check({31'h0, c1 != c0}, 32'h1);
    $display("test boot done");
    wr(`WDR_OFF_CONTROL, 32'h2, 2'b00);
    span(300);
    check({31'h0, c1 == c0}, 32'h1);
    wr(`WDR_OFF_CONTROL, 32'h0, 2'b00);
    wr(`WDR_OFF_COMMAND, 32'h2, 2'b00);
    wr(`WDR_OFF_CONTROL, 32'h2, 2'b00);
    rd(`WDR_OFF_CONTROL, 32'h8, 32'h1F8, 2'b00);
    span(300);
    check({31'h0, c1 != c0}, 32'h1);
    $display("test disable done");
    for (int p = 0; p < 2; p++) begin
      rl = 8'($urandom_range(8'hF0, 0));
      wr(`WDR_OFF_CONTROL, 32'(p), 2'b00);
      wr(`WDR_OFF_RELOAD, {24'h0, rl}, 2'b00);
      wr(`WDR_OFF_COMMAND, 32'h1, 2'b00);
      span(256);
      check({31'h0, c0 - {16'h0, rl, 8'h00} < 32'd8}, 32'h1);
      check({31'h0, (c1 - c0) inside {[(p ? 1 : 128) : (p ? 3 : 134)]}}, 32'h1);
    end
    $display("test rates done");
    wr(`WDR_OFF_CONTROL, 32'h0, 2'b00);
    wr(`WDR_OFF_RELOAD, 32'hFF, 2'b00);
    wr(`WDR_OFF_COMMAND, 32'h1, 2'b00);
    watch_out();
    check({31'h0, t inside {[505:520]}}, 32'h1);
    check({31'h0, oe_seen}, 32'h0);
    wait_idle();
    rd(`WDR_OFF_CONTROL, 32'h10, 32'h1F8, 2'b00);
    $display("test overflow done");
    for (int m = 1; m >= 0; m--) begin
      wdr_ext_circuit_i.set_mode(m[0]);
      wr(`WDR_OFF_COMMAND, 32'h2, 2'b00);
      wr(`WDR_OFF_CONTROL, 32'h4, 2'b00);
      wr(`WDR_OFF_COMMAND, 32'h4, 2'b00);
      watch_out();
      check({31'h0, oe_seen}, {31'h0, m[0]});
      wait_idle();
      rd(`WDR_OFF_CONTROL, 32'h20, 32'h1F8, 2'b00);
    end
    $display("test software reset done");
    wdr_ext_circuit_i.set_mode(1'b1);
    for (int k = 0; k < 3; k++) begin
      wr(`WDR_OFF_COMMAND, 32'h2, 2'b00);
      wdr_ext_circuit_i.pulse(lens[k]);
      wait_idle();
      rd(`WDR_OFF_CONTROL, fexp[k], fmsk[k], 2'b00);
    end
    wr(`WDR_OFF_COMMAND, 32'h2, 2'b00);
    wdr_ext_circuit_i.pon_pulse();
    wait_idle();
    rd(`WDR_OFF_CONTROL, 32'h100, 32'h1F0, 2'b00);
    $display("test hardware reset done");
    wr(`WDR_OFF_IRQ_MASK, 32'h0, 2'b00);
    check({31'h0, irq}, 32'h0);
    wr(`WDR_OFF_IRQ_MASK, 32'h2, 2'b00);
    check({31'h0, irq}, 32'h1);
    wr(`WDR_OFF_IRQ_STATUS, 32'h3, 2'b00);
    check({31'h0, irq}, 32'h0);
    wr(8'h40, 32'h1, 2'b10);
    rd(8'h40, 32'h0, 32'hFFFFFFFF, 2'b10);
    $display("test irq and map done");
    test_done();
  end
  // hang guard, about 50k cycles
  initial begin
    #1000000;
    n_mismatch++;
    test_done();
  end
endmodule
